//--- hw/rxcah_pkg.sv
/*
  Shared constants of the receive channel assessment and hop block:
  register byte offsets, field positions, reset values, radio state codes.
  Assumes a 20 MHz reference clock and a 32-bit APB register bus.
*/
package rxcah_pkg;
  localparam int unsigned CLK_HZ = 20000000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLEEP = 8'h04;
  localparam logic [7:0] OFS_STRENGTH = 8'h08;
  localparam logic [7:0] OFS_HOP = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_FREQ = 8'h14;
  localparam logic [7:0] OFS_CDR = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_WAKE_EN = 0;
  localparam int unsigned CTRL_MUTE = 1;
  localparam int unsigned CTRL_CDR_LO = 2;
  localparam int unsigned CTRL_VALID_SRC = 4;
  localparam int unsigned CTRL_EXT_SRC = 5;
  localparam int unsigned CTRL_PIN_EN = 6;
  localparam int unsigned CTRL_W = 7;

  // Strength configuration fields
  localparam int unsigned SCFG_ORDER_LO = 0;
  localparam int unsigned SCFG_LATCH_LO = 4;
  localparam int unsigned SCFG_THRESH_LO = 8;
  localparam int unsigned SCFG_JUMPS_LO = 16;

  // Hop register fields
  localparam int unsigned HOP_STEP_LO = 0;
  localparam int unsigned HOP_CHAN_LO = 8;

  // Status register fields
  localparam int unsigned STAT_DBM_LO = 8;
  localparam int unsigned STAT_SUPPLY = 16;
  localparam int unsigned STAT_ABOVE = 17;
  localparam int unsigned STAT_JUMP_OK = 18;
  localparam int unsigned STAT_CAL_BUSY = 19;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [30:0] SLEEP_RST = 31'h0000_0020;
  localparam logic [17:0] SCFG_RST = 18'h3_0000;
  localparam logic [15:0] HOP_RST = 16'h0000;
  localparam logic [15:0] CDR_RST = 16'h0064;

  // Sleep interval limits in slow ticks: 0.03125 ms .. 41,922,560 ms at 32 kHz
  localparam logic [30:0] SLEEP_MIN = 31'h0000_0001;
  localparam logic [30:0] SLEEP_MAX = 31'h4FF6_0000;

  // Hop step in Hz
  localparam logic [11:0] HOP_STEP_HZ = 12'h9C4;

  // Strength path
  localparam logic [7:0] STRENGTH_MAX = 8'hFF;
  localparam logic [2:0] ORDER_MAX = 3'h7;

  // Fewest jumps at select value zero
  localparam logic [2:0] JUMP_BASE = 3'h2;

  // Radio state codes
  localparam logic [3:0] ST_SLEEP = 4'h1;
  localparam logic [3:0] ST_STBY = 4'h2;
  localparam logic [3:0] ST_RFS = 4'h3;
  localparam logic [3:0] ST_TFS = 4'h4;
  localparam logic [3:0] ST_RX = 4'h5;
  localparam logic [3:0] ST_TX = 4'h6;

  // Latch select codes
  localparam logic [1:0] LATCH_LIVE = 2'h0;
  localparam logic [1:0] LATCH_PREAMBLE = 2'h1;
  localparam logic [1:0] LATCH_SYNC = 2'h2;
  localparam logic [1:0] LATCH_PACKET = 2'h3;

  typedef enum logic [1:0] {
    RXCAH_CDR_COUNT,
    RXCAH_CDR_TRACK,
    RXCAH_CDR_MANCH,
    RXCAH_CDR_SPARE
  } rxcah_cdr_t;
endpackage : rxcah_pkg

//--- hw/rxcah_top.sv
/*
  Receive channel assessment and hop support logic: sleep timer, supply
  check trigger, strength filter/latch/compare, phase jump qualifier with
  data mute, clock data recovery and hop frequency offset. APB slave.
  Assumes all inputs synchronous to i_ref_clk; the slow oscillator arrives
  as a one-cycle tick per oscillator period.
*/
// Local design decisions: register access over APB and the placing of the registers.
// Summary of operation
// [R1] Wake enabled: sleep timer on slow oscillator ticks wakes radio from sleep.
// [R2] Sleep interval programmable from 0.03125 ms to 41,922,560 ms.
// [R3] Slow oscillator calibrated at power-up and periodically to within 1%.
// [R4] One supply check per tuning from sleep/standby; result readable in status.
// [R5] Strength is sum of in-phase and quadrature indicator values.
// [R6] Successive filter then averaging filter, order from 3-bit field.
// [R7] Filtered code converted to dBm; raw and dBm values readable.
// [R8] 2-bit select: live strength or latched at preamble, sync, packet.
// [R9] Live strength above 8-bit threshold gives 1, else 0.
// [R10] Threshold result selectable for valid interrupt and window extension.
// [R11] Each 0-to-1 or 1-to-0 transition of demodulated data is one jump.
// [R12] 2-bit field sets jumps needed to declare a wanted signal.
// [R13] Detector also needs valid deviation and SNR over 7 dB.
// [R14] Detector result selectable for valid interrupt or window extension.
// [R15] Direct mode with mute set: data suppressed while no wanted signal.
// [R16] Software should pick four jumps, fewer for short receive windows.
// [R17] Recovered symbol clock used internally and routable to a pin.
// [R18] Three recovery schemes: counting, tracking, Manchester counting variant.
// [R19] Tracking scheme follows rate error up to 15.6%.
// [R20] Frequency offset is 2.5 kHz times hop step times channel index.
// [R21] Software sets hop step once, then changes only the channel index.
// [R22] Software rewrites a loop parameter before receiving on some channels.
// [R23] Timer counts to interval, issues one wake request, restarts.
module rxcah_top
  import rxcah_pkg::*;
#(
  parameter int unsigned CAL_TICKS = 32000
) (
  input wire logic i_ref_clk, // 20 MHz clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic i_slow_wake_oscillator_tick, // One pulse per slow period
  input wire logic i_cal_done, // Slow oscillator trim finished
  output logic o_cal_req, // Calibration request pulse
  input wire logic [3:0] i_radio_state, // Radio state code
  output logic o_wake_req, // Wake request pulse
  output logic o_supply_check_req, // Supply check start pulse
  input wire logic i_supply_done, // Supply check finished
  input wire logic i_supply_low, // Supply check outcome
  input wire logic i_strength_valid, // Indicator sample strobe
  input wire logic [7:0] i_strength_i, // In-phase indicator
  input wire logic [7:0] i_strength_q, // Quadrature indicator
  input wire logic i_preamble_det, // Preamble detected pulse
  input wire logic i_sync_det, // Sync detected pulse
  input wire logic i_packet_done, // Packet received pulse
  input wire logic i_demod_data, // FSK demodulated data
  input wire logic i_dev_ok, // Deviation judged valid
  input wire logic i_snr_ok, // SNR above 7 dB
  input wire logic i_fsk_mode, // FSK demodulation active
  input wire logic i_direct_mode, // Direct data mode
  output logic o_demod_data, // Possibly muted data
  output logic o_signal_valid_irq, // Signal valid source
  output logic o_rx_extend, // Super-low-power window extension
  output logic o_cdr_clk, // Recovered clock, internal use
  output logic o_cdr_clk_pin, // Recovered clock for pin
  output logic [27:0] o_freq_offset // Hop offset in Hz
);

  logic [CTRL_W-1:0] ctrl;
  logic [30:0] sleep_ticks;
  logic [17:0] scfg;
  logic [15:0] hop;
  logic [15:0] cdr_half;
  logic [30:0] sleep_cnt;
  logic [15:0] cal_cnt;
  logic cal_busy;
  logic cal_boot;
  logic [3:0] prev_state;
  logic supply_result;
  logic [7:0] succ;
  logic [15:0] avg_acc;
  logic [7:0] strength_raw_value;
  logic [7:0] strength_live;
  logic [2:0] jump_cnt;
  logic [15:0] gap_cnt;
  logic demod_d;
  logic [15:0] cdr_cnt;
  logic [15:0] cdr_period;
  logic [15:0] edge_gap;
  logic cdr_clk;

  function automatic logic [7:0] sat_sum(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_sum = s[8] ? STRENGTH_MAX : s[7:0];
  endfunction

  function automatic logic is_quiet(input logic [3:0] st);
    is_quiet = (st == ST_SLEEP) || (st == ST_STBY);
  endfunction

  function automatic logic is_tuned(input logic [3:0] st);
    is_tuned = (st == ST_RFS) || (st == ST_TFS) || (st == ST_RX) || (st == ST_TX);
  endfunction

  // Register fields
  wire wake_en = ctrl[CTRL_WAKE_EN];
  wire mute_en = ctrl[CTRL_MUTE];
  wire rxcah_cdr_t cdr_mode = rxcah_cdr_t'(ctrl[CTRL_CDR_LO +: 2]);
  wire valid_src = ctrl[CTRL_VALID_SRC];
  wire ext_src = ctrl[CTRL_EXT_SRC];
  wire pin_en = ctrl[CTRL_PIN_EN];
  wire [2:0] strength_average_order = scfg[SCFG_ORDER_LO +: 3];
  wire [1:0] strength_latch_select = scfg[SCFG_LATCH_LO +: 2];
  wire [7:0] strength_threshold = scfg[SCFG_THRESH_LO +: 8];
  wire [1:0] jump_count_select = scfg[SCFG_JUMPS_LO +: 2];
  wire [7:0] hop_step_size = hop[HOP_STEP_LO +: 8];
  wire [7:0] hop_channel_index = hop[HOP_CHAN_LO +: 8];

  // APB decode
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite & i_ce;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_sleep = (paddr == OFS_SLEEP);
  wire hit_strength = (paddr == OFS_STRENGTH);
  wire hit_hop = (paddr == OFS_HOP);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_freq = (paddr == OFS_FREQ);
  wire hit_cdr = (paddr == OFS_CDR);
  wire hit_any = hit_ctrl | hit_sleep | hit_strength | hit_hop | hit_status | hit_freq | hit_cdr;
  // Out-of-range interval is clamped so the timer never stalls
  wire [30:0] sleep_wdata = (pwdata[30:0] < SLEEP_MIN) ? SLEEP_MIN :
                            (pwdata[30:0] > SLEEP_MAX) ? SLEEP_MAX : pwdata[30:0]; // [R2]

  wire [7:0] strength_dbm_value;
  wire strength_above;
  wire jump_ok;
  wire [31:0] status_word;
  wire [31:0] rd_mux;
  wire [27:0] freq_calc;

  assign status_word = {12'h000, cal_busy, jump_ok, strength_above, supply_result,
                        strength_dbm_value, strength_raw_value}; // [R4] [R7]
  assign rd_mux = hit_ctrl ? {25'h000_0000, ctrl} :
                  hit_sleep ? {1'b0, sleep_ticks} :
                  hit_strength ? {14'h0000, scfg} :
                  hit_hop ? {16'h0000, hop} :
                  hit_status ? status_word :
                  hit_freq ? {4'h0, o_freq_offset} :
                  hit_cdr ? {16'h0000, cdr_half} : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~hit_any;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata <= 32'h0000_0000;
    end else if (i_ce && psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RST;
      sleep_ticks <= SLEEP_RST;
      scfg <= SCFG_RST;
      hop <= HOP_RST;
      cdr_half <= CDR_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end else if (hit_sleep) begin
        sleep_ticks <= sleep_wdata;
      end else if (hit_strength) begin
        scfg <= pwdata[17:0];
      end else if (hit_hop) begin
        hop <= pwdata[15:0]; // [R21]
      end else if (hit_cdr) begin
        cdr_half <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // Sleep timer
  wire timer_run = wake_en && (i_radio_state == ST_SLEEP); // [R1]
  wire sleep_tc = timer_run && i_slow_wake_oscillator_tick && (sleep_cnt + 31'h1 >= sleep_ticks);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_cnt <= 31'h0000_0000;
      o_wake_req <= 1'b0;
    end else if (i_ce) begin
      o_wake_req <= sleep_tc; // [R23]
      if (!timer_run || sleep_tc) begin
        sleep_cnt <= 31'h0000_0000; // [R23]
      end else if (i_slow_wake_oscillator_tick) begin
        sleep_cnt <= sleep_cnt + 31'h1; // [R1]
      end
    end
  end

  // Oscillator calibration: once after reset, then every CAL_TICKS slow periods
  wire cal_due = cal_boot || (i_slow_wake_oscillator_tick && cal_cnt == CAL_TICKS[15:0] - 16'h1);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_boot <= 1'b1;
      cal_cnt <= 16'h0000;
      cal_busy <= 1'b0;
      o_cal_req <= 1'b0;
    end else if (i_ce) begin
      cal_boot <= 1'b0;
      o_cal_req <= cal_due && !cal_busy; // [R3]
      if (cal_due && !cal_busy) begin
        cal_busy <= 1'b1; // [R3]
      end else if (i_cal_done) begin
        cal_busy <= 1'b0;
      end
      if (cal_due) begin
        cal_cnt <= 16'h0000;
      end else if (i_slow_wake_oscillator_tick) begin
        cal_cnt <= cal_cnt + 16'h1;
      end
    end
  end

  // Supply check on each tuning from sleep or standby
  wire tune_edge = is_quiet(prev_state) && is_tuned(i_radio_state);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_state <= ST_SLEEP;
      o_supply_check_req <= 1'b0;
      supply_result <= 1'b0;
    end else if (i_ce) begin
      prev_state <= i_radio_state;
      o_supply_check_req <= tune_edge; // [R4]
      if (i_supply_done) begin
        supply_result <= i_supply_low; // [R4]
      end
    end
  end

  // Strength path
  wire [7:0] strength_sample = sat_sum(i_strength_i, i_strength_q); // [R5]
  wire [8:0] succ_sum = {1'b0, succ} + {1'b0, strength_sample};
  wire [15:0] avg_out = avg_acc >> strength_average_order;
  wire [15:0] avg_next = avg_acc - avg_out + {8'h00, succ}; // [R6]
  wire latch_event = (strength_latch_select == LATCH_PREAMBLE && i_preamble_det) ||
                     (strength_latch_select == LATCH_SYNC && i_sync_det) ||
                     (strength_latch_select == LATCH_PACKET && i_packet_done);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      succ <= 8'h00;
      avg_acc <= 16'h0000;
      strength_live <= 8'h00;
      strength_raw_value <= 8'h00;
    end else if (i_ce) begin
      if (i_strength_valid) begin
        succ <= succ_sum[8:1]; // [R6]
        avg_acc <= avg_next; // [R6]
      end
      strength_live <= (avg_out[15:8] != 8'h00) ? STRENGTH_MAX : avg_out[7:0];
      if (strength_latch_select == LATCH_LIVE || latch_event) begin
        strength_raw_value <= strength_live; // [R8]
      end
    end
  end

  // Offset from code to dBm, two's complement result
  localparam logic [7:0] DBM_OFFSET = 8'h94;
  assign strength_dbm_value = strength_raw_value - DBM_OFFSET; // [R7]
  assign strength_above = strength_live > strength_threshold; // [R9]

  // Phase jump detector
  wire data_edge = (i_demod_data != demod_d);
  wire [2:0] jumps_needed = JUMP_BASE + {1'b0, jump_count_select}; // [R12]
  // A long quiet spell means the jump run is broken
  wire [15:0] gap_limit = {cdr_half[13:0], 2'b00};
  assign jump_ok = (jump_cnt >= jumps_needed) && i_dev_ok && i_snr_ok; // [R13]

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      demod_d <= 1'b0;
      jump_cnt <= 3'h0;
      gap_cnt <= 16'h0000;
    end else if (i_ce) begin
      demod_d <= i_demod_data;
      if (!i_fsk_mode || gap_cnt >= gap_limit) begin
        jump_cnt <= 3'h0;
        gap_cnt <= 16'h0000;
      end else if (data_edge) begin
        gap_cnt <= 16'h0000;
        if (jump_cnt != ORDER_MAX) begin
          jump_cnt <= jump_cnt + 3'h1; // [R11]
        end
      end else begin
        gap_cnt <= gap_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_signal_valid_irq <= 1'b0;
      o_rx_extend <= 1'b0;
      o_demod_data <= 1'b0;
    end else if (i_ce) begin
      o_signal_valid_irq <= valid_src ? jump_ok : strength_above; // [R10] [R14]
      o_rx_extend <= ext_src ? jump_ok : strength_above; // [R10] [R14]
      o_demod_data <= i_demod_data & ~(i_direct_mode & mute_en & ~jump_ok); // [R15]
    end
  end

  // Clock data recovery
  wire [15:0] track_lo = cdr_half - (cdr_half >> 3) - (cdr_half >> 5); // [R19]
  wire [15:0] track_hi = cdr_half + (cdr_half >> 3) + (cdr_half >> 5); // [R19]
  wire gap_in_range = (edge_gap >= track_lo) && (edge_gap <= track_hi);
  // Manchester: only edges spaced three quarters of a half-symbol or more realign phase
  wire manch_edge = edge_gap >= (cdr_period - (cdr_period >> 2));
  logic resync;
  always_comb begin
    resync = 1'b0;
    case (cdr_mode)
      RXCAH_CDR_COUNT: resync = data_edge;
      RXCAH_CDR_TRACK: resync = data_edge;
      RXCAH_CDR_MANCH: resync = data_edge && manch_edge;
      default: resync = data_edge;
    endcase
  end // [R18]

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cdr_cnt <= 16'h0000;
      cdr_period <= CDR_RST;
      edge_gap <= 16'h0000;
      cdr_clk <= 1'b0;
    end else if (i_ce) begin
      if (data_edge) begin
        edge_gap <= 16'h0000;
      end else if (edge_gap != 16'hFFFF) begin
        edge_gap <= edge_gap + 16'h1;
      end
      if (cdr_mode == RXCAH_CDR_TRACK && data_edge && gap_in_range) begin
        cdr_period <= edge_gap; // [R19]
      end else if (cdr_mode != RXCAH_CDR_TRACK) begin
        cdr_period <= cdr_half;
      end
      if (resync) begin
        cdr_cnt <= 16'h0000; // [R18]
        cdr_clk <= 1'b0;
      end else if (cdr_cnt + 16'h1 >= cdr_period) begin
        cdr_cnt <= 16'h0000;
        cdr_clk <= ~cdr_clk; // [R17]
      end else begin
        cdr_cnt <= cdr_cnt + 16'h1;
      end
    end
  end

  assign o_cdr_clk = cdr_clk; // [R17]
  assign o_cdr_clk_pin = cdr_clk & pin_en; // [R17]

  // Hop offset: step and channel product, times 2.5 kHz
  wire [15:0] hop_prod = hop_step_size * hop_channel_index;
  // Widen before the multiply so the product is not cut to 16 bits
  assign freq_calc = 28'(hop_prod) * 28'(HOP_STEP_HZ); // [R20]

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_freq_offset <= 28'h000_0000;
    end else if (i_ce) begin
      o_freq_offset <= freq_calc; // [R20]
    end
  end

endmodule // rxcah_top

//--- sim/rxcah_chk_sva.sv
/*
  Port checker for rxcah_top, bound in.
  Assumes i_ce held high.
*/
module rxcah_chk
  import rxcah_pkg::*;
(
  input wire logic i_ref_clk, // Clock
  input wire logic i_resetn, // Reset
  input wire logic i_ce, // Enable
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [7:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic i_slow_wake_oscillator_tick, // Slow tick
  input wire logic [3:0] i_radio_state, // State
  input wire logic o_wake_req, // Wake
  input wire logic o_supply_check_req, // Supply check
  input wire logic o_cal_req, // Calibration
  input wire logic i_demod_data, // Data in
  input wire logic o_demod_data, // Data out
  input wire logic o_cdr_clk, // Clock
  input wire logic o_cdr_clk_pin, // Pin clock
  input wire logic [27:0] o_freq_offset // Offset
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  wire idle_st = (i_radio_state == ST_SLEEP) || (i_radio_state == ST_STBY);
  wire tune_st = (i_radio_state >= ST_RFS) && (i_radio_state <= ST_TX);
  sequence s_tune;
    idle_st ##1 tune_st;
  endsequence
  sequence s_hop_wr;
    psel && penable && pwrite && i_ce && (paddr == OFS_HOP);
  endsequence
  property p_supply_req;
    s_tune |=> o_supply_check_req;
  endproperty
  a_supply_req: assert property (p_supply_req) else $error("supply check missing");
  property p_supply_cause;
    o_supply_check_req |-> $past(tune_st) && $past(idle_st, 2);
  endproperty
  a_supply_cause: assert property (p_supply_cause) else $error("stray supply check");
  property p_wake_pulse;
    o_wake_req |=> !o_wake_req;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
  property p_wake_cause;
    o_wake_req |-> $past(i_slow_wake_oscillator_tick) && ($past(i_radio_state) == ST_SLEEP);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without tick in sleep");
  property p_cal_pulse;
    o_cal_req |=> !o_cal_req;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("calibration not a pulse");
  property p_mute;
    o_demod_data |-> $past(i_demod_data);
  endproperty
  a_mute: assert property (p_mute) else $error("data out not from data in");
  property p_pin;
    o_cdr_clk_pin |-> o_cdr_clk;
  endproperty
  a_pin: assert property (p_pin) else $error("pin clock without clock");
  property p_freq;
    s_hop_wr |-> ##2 o_freq_offset == 28'($past(pwdata[7:0], 2))
      * 28'($past(pwdata[15:8], 2)) * 28'(HOP_STEP_HZ);
  endproperty
  a_freq: assert property (p_freq) else $error("hop offset wrong");
endmodule // rxcah_chk

bind rxcah_top rxcah_chk i_rxcah_chk (.i_ref_clk, .i_resetn, .i_ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .i_slow_wake_oscillator_tick, .i_radio_state, .o_wake_req,
  .o_supply_check_req, .o_cal_req, .i_demod_data, .o_demod_data, .o_cdr_clk,
  .o_cdr_clk_pin, .o_freq_offset);

//--- sim/rxcah_top_tb.sv
/*
  Self-checking bench for rxcah_top.
  Assumes the checker file is compiled too.
*/
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module rxcah_top_tb
  import rxcah_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic i_slow_wake_oscillator_tick = 1'b0, i_cal_done = 1'b0, o_cal_req, er;
  logic [3:0] i_radio_state = ST_STBY;
  logic o_wake_req, o_supply_check_req, i_supply_done = 1'b0, i_supply_low = 1'b0;
  logic i_strength_valid = 1'b0, i_preamble_det = 1'b0, i_sync_det = 1'b0;
  logic [7:0] i_strength_i = 8'h00, i_strength_q = 8'h00;
  logic i_packet_done = 1'b0, i_demod_data = 1'b0, i_dev_ok = 1'b0, i_snr_ok = 1'b0;
  logic i_fsk_mode = 1'b0, i_direct_mode = 1'b0, low_val = 1'b0;
  logic o_demod_data, o_signal_valid_irq, o_rx_extend, o_cdr_clk, o_cdr_clk_pin;
  logic [27:0] o_freq_offset;
  int bad_count = 0, comparisons = 0, cyc = 0, dv = 0;
  int ticks = 0, wakes = 0, checks = 0, cals = 0;

  rxcah_top #(.CAL_TICKS(8)) i_rxcah_top (.*);

  always #25 i_ref_clk = ~i_ref_clk;

  // Analog side answers each request one cycle later
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    dv <= (dv == 624) ? 0 : dv + 1;
    i_slow_wake_oscillator_tick <= (dv == 624);
    i_cal_done <= o_cal_req;
    i_supply_done <= o_supply_check_req;
    i_supply_low <= low_val;
    if (i_slow_wake_oscillator_tick) ticks <= ticks + 1;
    if (o_wake_req) wakes <= wakes + 1;
    if (o_supply_check_req) checks <= checks + 1;
    if (o_cal_req) cals <= cals + 1;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    @(posedge i_ref_clk);
    while (pready !== 1'b1) @(posedge i_ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat;
    apb(1'b0, OFS_STATUS, 32'h0);
  endtask

  task automatic feed(input logic [7:0] a, input logic [7:0] b, input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      i_strength_valid <= 1'b1;
      i_strength_i <= a;
      i_strength_q <= b;
      @(posedge i_ref_clk);
      i_strength_valid <= 1'b0;
    end
  endtask

  task automatic pulse(input int k);
    @(posedge i_ref_clk);
    i_preamble_det <= (k == 1);
    i_sync_det <= (k == 2);
    i_packet_done <= (k == 3);
    @(posedge i_ref_clk);
    {i_preamble_det, i_sync_det, i_packet_done} <= 3'h0;
  endtask

  task automatic t_reset;
    logic [7:0] ofs [0:4] = '{OFS_CTRL, OFS_SLEEP, OFS_STRENGTH, OFS_HOP, OFS_CDR};
    logic [31:0] ex [0:4] = '{32'h0, 32'h20, 32'h3_0000, 32'h0, 32'h64};
    `CHK("power-up cal", 1'b1, cals >= 1)
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, ofs[k], 32'h0);
      `CHK("reset value", ex[k], rd)
    end
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
  endtask

  task automatic t_hop;
    logic [7:0] st [0:3] = '{8'hFF, 8'h01, 8'h12, 8'h12};
    logic [7:0] ch [0:3] = '{8'hFF, 8'h00, 8'h34, 8'h01};
    logic [27:0] e;
    for (int k = 0; k < 4; k++) begin
      e = 28'(st[k]) * 28'(ch[k]) * 28'(HOP_STEP_HZ);
      apb(1'b1, OFS_HOP, 32'({ch[k], st[k]}));
      // Offset register follows the hop write by one cycle
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      `CHK("offset", e, o_freq_offset)
      apb(1'b0, OFS_FREQ, 32'h0);
      `CHK("offset reg", e, rd[27:0])
    end
  endtask

  task automatic t_supply;
    logic [3:0] tg [0:3] = '{ST_RFS, ST_TFS, ST_RX, ST_TX};
    int c0;
    for (int k = 0; k < 4; k++) begin
      i_radio_state <= (k % 2) ? ST_SLEEP : ST_STBY;
      low_val <= 1'(k % 2);
      repeat (3) @(posedge i_ref_clk);
      c0 = checks;
      i_radio_state <= tg[k];
      repeat (4) @(posedge i_ref_clk);
      `CHK("checks", 1, checks - c0)
      stat();
      `CHK("supply result", 1'(k % 2), rd[STAT_SUPPLY])
    end
    c0 = checks;
    i_radio_state <= ST_RX;
    repeat (4) @(posedge i_ref_clk);
    `CHK("no check", 0, checks - c0)
  endtask

  task automatic t_strength;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_STRENGTH, 32'h2_1000);
    feed(8'h40, 8'h40, 40);
    stat();
    `CHK("raw", 1'b1, rd[7:0] >= 8'h7E && rd[7:0] <= 8'h80)
    `CHK("dbm", 8'(rd[7:0] - 8'h94), rd[15:8])
    `CHK("above", 1'b1, rd[STAT_ABOVE])
    @(negedge i_ref_clk);
    `CHK("irq", 1'b1, o_signal_valid_irq)
    `CHK("extend", 1'b1, o_rx_extend)
    apb(1'b1, OFS_STRENGTH, 32'h2_FF00);
    stat();
    `CHK("below", 1'b0, rd[STAT_ABOVE])
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, OFS_STRENGTH, 32'h2_1000 | 32'(k << 4));
      feed(8'hF0, 8'hF0, 30);
      pulse(k);
      feed(8'h10, 8'h10, 30);
      stat();
      `CHK("held", 1'b1, rd[7:0] >= 8'hF0)
      pulse(k);
      stat();
      `CHK("relatched", 1'b1, rd[7:0] <= 8'h21)
    end
  endtask

  task automatic t_jump;
    apb(1'b1, OFS_CDR, 32'h10);
    apb(1'b1, OFS_STRENGTH, 32'h0_1000);
    apb(1'b1, OFS_CTRL, 32'h32);
    {i_fsk_mode, i_direct_mode, i_dev_ok, i_snr_ok, i_demod_data} <= 5'h1F;
    repeat (100) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK("muted", 1'b0, o_demod_data)
    i_demod_data <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    stat();
    `CHK("one jump", 1'b0, rd[STAT_JUMP_OK])
    i_demod_data <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    stat();
    `CHK("two jumps", 1'b1, rd[STAT_JUMP_OK])
    @(negedge i_ref_clk);
    `CHK("irq", 1'b1, o_signal_valid_irq)
    `CHK("extend", 1'b1, o_rx_extend)
    `CHK("unmuted", 1'b1, o_demod_data)
    i_snr_ok <= 1'b0;
    stat();
    `CHK("low snr", 1'b0, rd[STAT_JUMP_OK])
    {i_snr_ok, i_dev_ok} <= 2'h2;
    stat();
    `CHK("bad deviation", 1'b0, rd[STAT_JUMP_OK])
    i_fsk_mode <= 1'b0;
  endtask

  task automatic t_cdr;
    int n, pn;
    logic prev;
    apb(1'b1, OFS_CDR, 32'h4);
    for (int s = 0; s < 5; s++) begin
      apb(1'b1, OFS_CTRL, (s < 4) ? 32'h40 | 32'(s << 2) : 32'h0);
      repeat (4) @(posedge i_ref_clk);
      n = 0;
      pn = 0;
      prev = o_cdr_clk;
      repeat (40) begin
        @(negedge i_ref_clk);
        if (o_cdr_clk !== prev) n++;
        prev = o_cdr_clk;
        if (o_cdr_clk_pin === 1'b1) pn++;
      end
      `CHK("cdr toggles", 10, n)
      `CHK("pin high", (s < 4) ? 20 : 0, pn)
    end
  endtask

  task automatic t_sleep;
    int n, t1;
    apb(1'b1, OFS_SLEEP, 32'h0);
    apb(1'b0, OFS_SLEEP, 32'h0);
    `CHK("min interval", 32'h1, rd)
    apb(1'b1, OFS_SLEEP, 32'h7FFF_FFFF);
    apb(1'b0, OFS_SLEEP, 32'h0);
    `CHK("max interval", 32'h4FF6_0000, rd)
    apb(1'b1, OFS_SLEEP, 32'h3);
    i_radio_state <= ST_SLEEP;
    apb(1'b1, OFS_CTRL, 32'h1);
    for (int w = 0; w < 2; w++) begin
      n = wakes;
      t1 = ticks;
      while (wakes == n && cyc < 59000) @(posedge i_ref_clk);
    end
    `CHK("ticks per wake", 3, ticks - t1)
    apb(1'b1, OFS_CTRL, 32'h0);
    n = wakes;
    repeat (2600) @(posedge i_ref_clk);
    `CHK("no wake disabled", n, wakes)
    `CHK("periodic cal", 1'b1, cals >= 2)
    i_radio_state <= ST_STBY;
  endtask

  task stop_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    t_reset();
    t_hop();
    t_supply();
    t_strength();
    t_jump();
    t_cdr();
    t_sleep();
    stop_test();
  end
endmodule // rxcah_top_tb
